// File: common/bsfc_defines.vh
// Purpose: Shared constants of the buck setpoint and fault control block.
// Assumes: A 40 MHz system clock; voltage levels in units of 0.125 mV.
// Notes:   Times are kept in their own unit; cycle counts are derived in code.
`ifndef BSFC_DEFINES_VH
`define BSFC_DEFINES_VH

// =====================================================================
// Clock and timing
`define BSFC_CLK_PERIOD_NS 25
`define BSFC_CLK_KHZ       40000
`define BSFC_RETRY_MS      10
`define BSFC_PHASE_DLY_NS  100
`define BSFC_RUN_LEN       16
`define BSFC_SLEW_DIV      40

// =====================================================================
// Channel layout and setpoint field widths
`define BSFC_NBUCK         3
`define BSFC_CODE_W        8
`define BSFC_LVL_W         15

// =====================================================================
// Reference ranges in 0.125 mV units
`define BSFC_LO_BASE       15'h12c0
`define BSFC_LO_STEP       15'h004b
`define BSFC_HI_BASE       15'h1900
`define BSFC_HI_STEP       15'h0064

// =====================================================================
// Global fault sequencer states
`define BSFC_ST_RUN        2'h0
`define BSFC_ST_FAULT      2'h1
`define BSFC_ST_RESTART    2'h2

`endif

// File: verilog/bsfc_slew.v
// Purpose: Slews one buck's active setpoint code toward its selected target.
// Assumes: step_tick is a one-cycle pulse setting the slew rate.
// Notes:   While the buck is off the code follows the target at once.
`timescale 1ns/100ps
module bsfc_slew #(
  parameter CODE_W = 8
) (
  // Clock, reset and enable
  input  wire              clk,
  input  wire              rst_n,
  input  wire              ce,
  // Control
  input  wire              step_tick,
  input  wire              load,
  input  wire [CODE_W-1:0] target,
  // Result
  output wire [CODE_W-1:0] code,
  output wire              busy
);

  reg [CODE_W-1:0] code_q;

  // =====================================================================
  // Ramp one code step per tick toward the target.
  always @(posedge clk) begin
    if (!rst_n) begin
      code_q <= {CODE_W{1'b0}};
    end else if (ce) begin
      if (load) begin
        code_q <= target;
      end else if (step_tick && (code_q < target)) begin
        code_q <= code_q + {{(CODE_W-1){1'b0}}, 1'b1};
      end else if (step_tick && (code_q > target)) begin
        code_q <= code_q - {{(CODE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign code = code_q;
  assign busy = (code_q != target);

endmodule

// File: verilog/bsfc_prot.v
// Purpose: Per-buck current-limit run counters, foldback, gating and short retry.
// Assumes: Comparator inputs are valid when cycle_tick pulses.
// Notes:   Run counters restart on any cycle that breaks the run.
`timescale 1ns/100ps
module bsfc_prot #(
  parameter RUN_LEN      = 16,
  parameter RETRY_CYCLES = 400000
) (
  // Clock, reset and enable
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // Comparators and state
  input  wire cycle_tick,
  input  wire warn_cmp,
  input  wire limit_cmp,
  input  wire valley_clear,
  input  wire uv30,
  input  wire in_reg,
  input  wire ss_done,
  input  wire enabled,
  // Results
  output wire warn_live,
  output wire warn_hit,
  output wire oc_hit,
  output wire foldback,
  output wire hs_block,
  output wire short_hit,
  output wire short_off
);

  reg [5:0]  warn_cnt_q;
  reg [5:0]  lim_cnt_q;
  reg        fold_q;
  reg        block_q;
  reg        short_q;
  reg [18:0] retry_q;

  // =====================================================================
  // Consecutive-cycle counters for 75 percent warning and full limit.
  always @(posedge clk) begin
    if (!rst_n) begin
      warn_cnt_q <= 6'h00;
      lim_cnt_q  <= 6'h00;
    end else if (ce && cycle_tick) begin
      if (!warn_cmp) warn_cnt_q <= 6'h00;
      else if (warn_cnt_q < RUN_LEN[5:0]) warn_cnt_q <= warn_cnt_q + 6'h01;
      if (!limit_cmp) lim_cnt_q <= 6'h00;
      else if (lim_cnt_q <= RUN_LEN[5:0]) lim_cnt_q <= lim_cnt_q + 6'h01;
    end
  end

  assign warn_live = (warn_cnt_q == RUN_LEN[5:0]);
  assign warn_hit  = ce && cycle_tick && warn_cmp
                     && (warn_cnt_q == RUN_LEN[5:0] - 6'h01);
  assign oc_hit    = ce && cycle_tick && limit_cmp;

  // =====================================================================
  // Foldback after more than the run length at the limit with output low.
  always @(posedge clk) begin
    if (!rst_n) begin
      fold_q <= 1'b0;
    end else if (ce) begin
      if (ss_done && uv30 && (lim_cnt_q > RUN_LEN[5:0])) fold_q <= 1'b1;
      else if (in_reg) fold_q <= 1'b0;
    end
  end

  // =====================================================================
  // Next high-side turn-on waits until low-side current is under valley.
  always @(posedge clk) begin
    if (!rst_n) begin
      block_q <= 1'b0;
    end else if (ce) begin
      if (limit_cmp) block_q <= 1'b1;
      else if (valley_clear) block_q <= 1'b0;
    end
  end

  // =====================================================================
  // Short shutdown with a timed restart attempt.
  always @(posedge clk) begin
    if (!rst_n) begin
      short_q <= 1'b0;
      retry_q <= 19'h00000;
    end else if (ce) begin
      if (!short_q && enabled && ss_done && uv30) begin
        short_q <= 1'b1;
        retry_q <= RETRY_CYCLES[18:0] - 19'h00001;
      end else if (short_q && (retry_q == 19'h00000)) begin
        short_q <= 1'b0;
      end else if (short_q) begin
        retry_q <= retry_q - 19'h00001;
      end
    end
  end

  assign foldback  = fold_q;
  assign hs_block  = block_q || limit_cmp;
  assign short_hit = ce && !short_q && enabled && ss_done && uv30;
  assign short_off = short_q;

endmodule

// File: verilog/bsfc_top.v
// Purpose: Setpoint, enable, phase and fault control for three buck regulators.
// Assumes: Settings arrive from the serial register file; pins are synchronous.
// Notes:   Per-buck vectors pack buck 1 in the low field.
`timescale 1ns/100ps
`include "bsfc_defines.vh"
module bsfc_top #(
  parameter NBUCK        = `BSFC_NBUCK,
  parameter CODE_W       = `BSFC_CODE_W,
  parameter LVL_W        = `BSFC_LVL_W,
  parameter RUN_LEN      = `BSFC_RUN_LEN,
  parameter SLEW_DIV     = `BSFC_SLEW_DIV,
  parameter RETRY_CYCLES = `BSFC_RETRY_MS * `BSFC_CLK_KHZ
) (
  // Clock, reset and enable
  input  wire                    sys_clk,
  input  wire                    rst_n,
  input  wire                    clk_en,
  // Host-written settings
  input  wire [NBUCK*CODE_W-1:0] setpoint_normal_code,
  input  wire [NBUCK*CODE_W-1:0] setpoint_scaled_code,
  input  wire [NBUCK-1:0]        regulator_enable_bit,
  input  wire [NBUCK-1:0]        turn_on_delay_select,
  input  wire [NBUCK-1:0]        turn_on_edge_select,
  input  wire [NBUCK*2-1:0]      current_limit_level,
  input  wire [NBUCK-1:0]        overcurrent_mask,
  input  wire [NBUCK-1:0]        current_warning_mask,
  input  wire [NBUCK-1:0]        short_fault_mask,
  input  wire                    status_read,
  // Factory straps
  input  wire [1:0]              reference_range_select,
  input  wire [NBUCK*NBUCK+NBUCK-1:0] factory_config_profile,
  // Pins and master clock level
  input  wire [NBUCK-1:0]        scale_ctrl_n,
  input  wire                    master_clk_level,
  // Analog comparators per buck
  input  wire [NBUCK-1:0]        sw_cycle_tick,
  input  wire [NBUCK-1:0]        warn_cmp,
  input  wire [NBUCK-1:0]        limit_cmp,
  input  wire [NBUCK-1:0]        valley_clear_cmp,
  input  wire [NBUCK-1:0]        uv30_cmp,
  input  wire [NBUCK-1:0]        in_reg_cmp,
  input  wire [NBUCK-1:0]        ss_done,
  // Power stage control
  output wire [NBUCK*LVL_W-1:0]  target_level,
  output wire [NBUCK*2-1:0]      limit_level_out,
  output wire [NBUCK-1:0]        foldback_sel,
  output wire [NBUCK-1:0]        force_pwm,
  output wire [NBUCK-1:0]        buck_run,
  output wire [NBUCK-1:0]        discharge_en,
  output wire [NBUCK-1:0]        hs_turn_on,
  output wire [NBUCK-1:0]        hs_cut,
  // Status and alert
  output wire [NBUCK-1:0]        current_warning_flag,
  output wire [NBUCK-1:0]        overcurrent_flag,
  output wire [NBUCK-1:0]        short_flag,
  output reg                     fault_alert_n,
  output reg                     system_restart
);

  localparam PHASE_CYC = (`BSFC_PHASE_DLY_NS + `BSFC_CLK_PERIOD_NS - 1) / `BSFC_CLK_PERIOD_NS;
  localparam ST_RUN     = `BSFC_ST_RUN;
  localparam ST_FAULT   = `BSFC_ST_FAULT;
  localparam ST_RESTART = `BSFC_ST_RESTART;

  reg  [1:0]               range_q;
  reg  [NBUCK*NBUCK+NBUCK-1:0] profile_q;
  reg                      strap_done_q;
  reg  [7:0]               slew_cnt_q;
  reg                      slew_tick_q;
  reg                      mclk_q;
  reg  [1:0]               gstate_q;
  reg  [18:0]              gtimer_q;
  wire [NBUCK-1:0]         cascade_off;
  wire [NBUCK-1:0]         unmasked_short;
  wire [NBUCK-1:0]         alert_src;
  wire [NBUCK-1:0]         run_now;
  wire                     global_off;

  // =====================================================================
  // Strap capture on the first enabled cycle after reset release.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      range_q      <= 2'h0;
      profile_q    <= {(NBUCK*NBUCK+NBUCK){1'b0}};
      strap_done_q <= 1'b0;
    end else if (clk_en && !strap_done_q) begin
      range_q      <= reference_range_select;
      profile_q    <= factory_config_profile;
      strap_done_q <= 1'b1;
    end
  end

  // =====================================================================
  // Shared slew-rate tick and master clock edge sampling.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      slew_cnt_q  <= 8'h00;
      slew_tick_q <= 1'b0;
      mclk_q      <= 1'b0;
    end else if (clk_en) begin
      mclk_q      <= master_clk_level;
      slew_tick_q <= (slew_cnt_q == SLEW_DIV[7:0] - 8'h01);
      if (slew_cnt_q == SLEW_DIV[7:0] - 8'h01) slew_cnt_q <= 8'h00;
      else slew_cnt_q <= slew_cnt_q + 8'h01;
    end
  end

  // =====================================================================
  // Global fault sequencer: all supplies off, then restart after the wait.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      gstate_q       <= ST_RUN;
      gtimer_q       <= 19'h00000;
      system_restart <= 1'b0;
    end else if (clk_en) begin
      system_restart <= 1'b0;
      case (gstate_q)
        ST_RUN: begin
          if (|unmasked_short) begin
            gstate_q <= ST_FAULT;
            gtimer_q <= RETRY_CYCLES[18:0] - 19'h00001;
          end
        end
        ST_FAULT: begin
          if (gtimer_q == 19'h00000) gstate_q <= ST_RESTART;
          else gtimer_q <= gtimer_q - 19'h00001;
        end
        ST_RESTART: begin
          system_restart <= 1'b1;
          gstate_q       <= ST_RUN;
        end
        default: begin
          gstate_q <= ST_RUN;
        end
      endcase
    end
  end

  assign global_off = (gstate_q != ST_RUN);

  // =====================================================================
  // Alert output is low while any unmasked latched flag stands.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_alert_n <= 1'b1;
    end else if (clk_en) begin
      fault_alert_n <= ~(|alert_src);
    end
  end

  // =====================================================================
  // Per-buck datapath, gating and status.
  genvar gi;
  genvar ti;
  generate
    for (gi = 0; gi < NBUCK; gi = gi + 1) begin : g_buck
      wire [CODE_W-1:0] sel_code;
      wire [CODE_W-1:0] act_code;
      wire              slew_busy;
      wire              rng_hi;
      wire              w_live;
      wire              w_hit;
      wire              oc_hit;
      wire              fold;
      wire              hs_blk;
      wire              sc_hit;
      wire              sc_off;
      wire              edge_now;
      wire [NBUCK-1:0]  trig_col;
      reg  [LVL_W-1:0]  lvl_q;
      reg  [1:0]        lim_q;
      reg               fold_q;
      reg               pwm_q;
      reg               run_q;
      reg               dis_q;
      reg               hs_q;
      reg               cut_q;
      reg  [PHASE_CYC:0] dly_q;
      reg               warn_q;
      reg               oc_q;
      reg               sc_q;

      // Scaling pin low selects the scaled code.
      assign sel_code = scale_ctrl_n[gi] ? setpoint_normal_code[gi*CODE_W +: CODE_W]
                                         : setpoint_scaled_code[gi*CODE_W +: CODE_W];
      // The third buck has only the high range.
      assign rng_hi = (gi < 2) ? range_q[gi % 2] : 1'b1;

      // Column of the profile: which triggers this buck depends on.
      for (ti = 0; ti < NBUCK; ti = ti + 1) begin : g_trig
        assign trig_col[ti] = profile_q[ti*NBUCK + gi];
      end

      // Dependents drop with a disabled trigger only where the profile says.
      assign cascade_off[gi] = |(trig_col & ~regulator_enable_bit
                                 & profile_q[NBUCK*NBUCK +: NBUCK]);
      assign run_now[gi] = regulator_enable_bit[gi] && !cascade_off[gi]
                           && !sc_off && !global_off;

      bsfc_slew #(
        .CODE_W (CODE_W)
      ) u_slew (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .ce        (clk_en),
        .step_tick (slew_tick_q),
        .load      (!run_q),
        .target    (sel_code),
        .code      (act_code),
        .busy      (slew_busy)
      );

      bsfc_prot #(
        .RUN_LEN      (RUN_LEN),
        .RETRY_CYCLES (RETRY_CYCLES)
      ) u_prot (
        .clk          (sys_clk),
        .rst_n        (rst_n),
        .ce           (clk_en),
        .cycle_tick   (sw_cycle_tick[gi]),
        .warn_cmp     (warn_cmp[gi]),
        .limit_cmp    (limit_cmp[gi]),
        .valley_clear (valley_clear_cmp[gi]),
        .uv30         (uv30_cmp[gi]),
        .in_reg       (in_reg_cmp[gi]),
        .ss_done      (ss_done[gi]),
        .enabled      (run_q),
        .warn_live    (w_live),
        .warn_hit     (w_hit),
        .oc_hit       (oc_hit),
        .foldback     (fold),
        .hs_block     (hs_blk),
        .short_hit    (sc_hit),
        .short_off    (sc_off)
      );

      // Chosen master clock edge, before the optional delay.
      assign edge_now = turn_on_edge_select[gi] ? (mclk_q && !master_clk_level)
                                                : (!mclk_q && master_clk_level);

      // Target level, limit, foldback, forced switching, run and discharge.
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          lvl_q  <= {LVL_W{1'b0}};
          lim_q  <= 2'h0;
          fold_q <= 1'b0;
          pwm_q  <= 1'b0;
          run_q  <= 1'b0;
          dis_q  <= 1'b1;
        end else if (clk_en) begin
          if (rng_hi) lvl_q <= `BSFC_HI_BASE + {7'h00, act_code} * `BSFC_HI_STEP;
          else lvl_q <= `BSFC_LO_BASE + {7'h00, act_code} * `BSFC_LO_STEP;
          lim_q  <= current_limit_level[gi*2 +: 2];
          fold_q <= fold;
          pwm_q  <= run_q && slew_busy;
          run_q  <= run_now[gi];
          dis_q  <= !run_now[gi];
        end
      end

      // Turn-on pulse with optional fixed delay, gated by the current limit.
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          dly_q <= {(PHASE_CYC+1){1'b0}};
          hs_q  <= 1'b0;
          cut_q <= 1'b0;
        end else if (clk_en) begin
          dly_q <= {dly_q[PHASE_CYC-1:0], edge_now};
          hs_q  <= run_q && !hs_blk
                   && (turn_on_delay_select[gi] ? dly_q[PHASE_CYC-1] : edge_now);
          cut_q <= run_q && limit_cmp[gi];
        end
      end

      // Latched flags: a new event wins over a read; a read clears only once gone.
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          warn_q <= 1'b0;
          oc_q   <= 1'b0;
          sc_q   <= 1'b0;
        end else if (clk_en) begin
          if (w_hit) warn_q <= 1'b1;
          else if (status_read && !w_live) warn_q <= 1'b0;
          if (oc_hit) oc_q <= 1'b1;
          else if (status_read && !limit_cmp[gi]) oc_q <= 1'b0;
          if (sc_hit) sc_q <= 1'b1;
          else if (status_read && !uv30_cmp[gi]) sc_q <= 1'b0;
        end
      end

      assign unmasked_short[gi] = sc_hit && !short_fault_mask[gi] && !overcurrent_mask[gi];
      assign alert_src[gi] = (warn_q && !current_warning_mask[gi] && !overcurrent_mask[gi])
                             || (oc_q && !overcurrent_mask[gi])
                             || (sc_q && !short_fault_mask[gi]);

      assign target_level[gi*LVL_W +: LVL_W] = lvl_q;
      assign limit_level_out[gi*2 +: 2]      = lim_q;
      assign foldback_sel[gi]                = fold_q;
      assign force_pwm[gi]                   = pwm_q;
      assign buck_run[gi]                    = run_q;
      assign discharge_en[gi]                = dis_q;
      assign hs_turn_on[gi]                  = hs_q;
      assign hs_cut[gi]                      = cut_q;
      assign current_warning_flag[gi]        = warn_q;
      assign overcurrent_flag[gi]            = oc_q;
      assign short_flag[gi]                  = sc_q;
    end
  endgenerate

endmodule

// File: bench/bsfc_properties.sv
// Purpose: Port assertions for the buck control top.
// Assumes: Straps stay constant for the whole run.
// Notes:   Buck 1 carries the range and slew checks.
`timescale 1ns/100ps
module bsfc_props (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // Settings and comparators
  input wire [1:0]  reference_range_select,
  input wire [23:0] setpoint_normal_code,
  input wire [23:0] setpoint_scaled_code,
  input wire [2:0]  regulator_enable_bit,
  input wire [2:0]  scale_ctrl_n,
  input wire [2:0]  limit_cmp,
  input wire [2:0]  current_warning_mask,
  input wire [2:0]  overcurrent_mask,
  input wire        status_read,
  // Outputs
  input wire [44:0] target_level,
  input wire [2:0]  force_pwm,
  input wire [2:0]  buck_run,
  input wire [2:0]  discharge_en,
  input wire [2:0]  hs_cut,
  input wire [2:0]  current_warning_flag,
  input wire        fault_alert_n
);
  // Buck 1 code selected by its scaling pin.
  wire [7:0] c1 = scale_ctrl_n[0] ? setpoint_normal_code[7:0] : setpoint_scaled_code[7:0];
  // Level in 0.125 mV units, and the size of a level change.
  function automatic [14:0] lv(input hi, input [7:0] c);
    lv = hi ? 15'h1900 + 15'h0064 * c : 15'h12c0 + 15'h004b * c;
  endfunction
  function automatic [14:0] dl(input [14:0] a, input [14:0] b);
    dl = (a > b) ? a - b : b - a;
  endfunction
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_dis; discharge_en == ~buck_run; endproperty
  a_dis: assert property (p_dis) else $error("discharge wrong");
  property p_off; $fell(regulator_enable_bit[0]) |-> ##[1:3] !buck_run[0]; endproperty
  a_off: assert property (p_off) else $error("buck stays on");
  property p_lv1; (!buck_run[0] && $stable(c1))[*4] |->
    target_level[14:0] == lv(reference_range_select[0], c1); endproperty
  a_lv1: assert property (p_lv1) else $error("level wrong");
  property p_pwm; buck_run[0] && scale_ctrl_n[0] && $changed(setpoint_normal_code[7:0])
    |-> ##[1:3] force_pwm[0]; endproperty
  a_pwm: assert property (p_pwm) else $error("no forced pwm");
  property p_slw; buck_run[0] && $past(buck_run[0]) && $past(buck_run[0], 2) |->
    dl(target_level[14:0], $past(target_level[14:0])) <= 15'h0064; endproperty
  a_slw: assert property (p_slw) else $error("level jump");
  property p_cut; limit_cmp[1] && buck_run[1] |=> hs_cut[1]; endproperty
  a_cut: assert property (p_cut) else $error("no cut");
  property p_stk; current_warning_flag[0] && !status_read |=> current_warning_flag[0];
  endproperty
  a_stk: assert property (p_stk) else $error("flag lost");
  property p_alr; $rose(current_warning_flag[0]) && !current_warning_mask[0]
    && !overcurrent_mask[0] |=> !fault_alert_n; endproperty
  a_alr: assert property (p_alr) else $error("no alert");
  c_alr: cover property ($fell(fault_alert_n));
  c_pwm: cover property ($rose(force_pwm[0]));
  c_sht: cover property ($fell(buck_run[2]));
endmodule
bind bsfc_top bsfc_props bsfc_props_inst (.*);

// File: bench/bsfc_host_model.sv
// Purpose: Host that writes the block settings.
// Assumes: Writes land by non-blocking assignment at a rising edge.
// Notes:   Masks pack short, warning and over-current fields.
`timescale 1ns/100ps
module bsfc_host_model (
  // Clock
  input  wire        sys_clk,
  // Settings; the range strap is never written here
  output reg  [23:0] setpoint_normal_code,
  output reg  [23:0] setpoint_scaled_code,
  output reg  [2:0]  regulator_enable_bit,
  output reg  [8:0]  masks,
  output reg         status_read
);
  // Writes both setpoint codes, the enables and the masks at one edge.
  task wr(input [23:0] n, input [23:0] s, input [2:0] en, input [8:0] m);
    @(posedge sys_clk);
    setpoint_normal_code <= n;
    setpoint_scaled_code <= s;
    regulator_enable_bit <= en;
    masks <= m;
  endtask
  // One-cycle status read.
  task rd;
    @(posedge sys_clk);
    status_read <= 1'b1;
    @(posedge sys_clk);
    status_read <= 1'b0;
  endtask
  initial begin
    {setpoint_normal_code, setpoint_scaled_code, regulator_enable_bit, masks} = 60'h0;
    status_read = 1'b0;
  end
endmodule

// File: bench/bsfc_top_tb.sv
// Purpose: Self-checking bench for the buck control top.
// Assumes: Retry of 20 cycles, slew tick every 2 cycles.
// Notes:   Drivers queue expectations; a negedge monitor compares them.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module bsfc_top_tb;
  // ==========================================================
  // Signals
  logic sys_clk, rst_n, clk_en, master_clk_level, rs_seen;
  logic [1:0] reference_range_select;
  logic [11:0] factory_config_profile;
  logic [5:0] current_limit_level;
  logic [2:0] scale_ctrl_n, sw_cycle_tick, warn_cmp, limit_cmp, uv30_cmp, ss_done;
  logic [2:0] valley_clear_cmp, in_reg_cmp, turn_on_delay_select, turn_on_edge_select;
  wire [23:0] setpoint_normal_code, setpoint_scaled_code;
  wire [8:0] masks;
  wire [2:0] regulator_enable_bit, foldback_sel, force_pwm, buck_run, discharge_en;
  wire [2:0] hs_turn_on, hs_cut, current_warning_flag, overcurrent_flag, short_flag;
  wire [2:0] overcurrent_mask = masks[2:0];
  wire [2:0] current_warning_mask = masks[5:3];
  wire [2:0] short_fault_mask = masks[8:6];
  wire [44:0] target_level;
  wire [5:0] limit_level_out;
  wire status_read, fault_alert_n, system_restart;
  int n_errors = 0, tests_run = 0, sel_q[$], i;
  logic [44:0] exp_q[$], got, want;
  logic [23:0] n, s;
  integer seed = 32'ha5b1;
  bsfc_top #(.RETRY_CYCLES(20), .SLEW_DIV(2)) bsfc_top_inst (.*);
  bsfc_host_model bsfc_host_model_inst (.*);
  // Clock, master clock and restart pulse catcher.
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) master_clk_level <= ~master_clk_level;
  always @(posedge sys_clk) if (system_restart === 1'b1) rs_seen <= 1'b1;
  // Expected levels: buck 1 low range, bucks 2 and 3 high range.
  function automatic [14:0] lv(input hi, input [7:0] c);
    lv = hi ? 15'h1900 + 15'h0064 * c : 15'h12c0 + 15'h004b * c;
  endfunction
  function automatic [44:0] tl(input [23:0] c);
    tl = {lv(1'b1, c[23:16]), lv(1'b1, c[15:8]), lv(1'b0, c[7:0])};
  endfunction
  function automatic [44:0] obs(input int k);
    obs = 45'h0;
    case (k)
      0: obs = target_level;
      1: obs[5:0] = {buck_run, discharge_en};
      2: obs[2:0] = force_pwm;
      3: obs[3:0] = {current_warning_flag, fault_alert_n};
      4: obs[5:0] = {short_flag, buck_run};
      5: obs[11:0] = {overcurrent_flag, foldback_sel, limit_level_out};
      default: obs[0] = rs_seen;
    endcase
  endfunction
  task ex(input int k, input [44:0] v);
    sel_q.push_back(k);
    exp_q.push_back(v);
  endtask
  task w(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Switching cycles with comparator levels held from each tick.
  task tk(input int c, input [2:0] wc, input [2:0] lc, input [2:0] uc);
    repeat (c) begin
      @(posedge sys_clk);
      sw_cycle_tick <= 3'h7;
      {warn_cmp, limit_cmp, uv30_cmp} <= {wc, lc, uc};
      @(posedge sys_clk);
      sw_cycle_tick <= 3'h0;
    end
  endtask
  task results;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Monitor takes every queued expectation, oldest first, at each falling edge.
  always @(negedge sys_clk) begin
    while (exp_q.size() > 0) begin
      got = obs(sel_q.pop_front());
      want = exp_q.pop_front();
      `CHK(got, want)
    end
  end
  // Watchdog.
  initial begin
    #75000;
    n_errors++;
    results();
  end
  // Main sequence.
  initial begin
    {sys_clk, rst_n, clk_en, master_clk_level, rs_seen} = 5'b00100;
    {scale_ctrl_n, sw_cycle_tick, warn_cmp, limit_cmp, uv30_cmp} = 15'h7000;
    {valley_clear_cmp, in_reg_cmp, ss_done} = 9'h1ff;
    {turn_on_delay_select, turn_on_edge_select, current_limit_level} = 12'h0;
    reference_range_select = 2'b10;
    factory_config_profile = 12'h004;
    w(4);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      n = $random(seed);
      s = (i == 0) ? 24'hffffff : $random(seed);
      bsfc_host_model_inst.wr(n, s, 3'h0, 9'h0);
      scale_ctrl_n <= {i[1], 1'b1, i[0]};
      {turn_on_delay_select, turn_on_edge_select, current_limit_level} <= $random(seed);
      w(6);
      ex(0, tl({i[1] ? n[23:16] : s[23:16], n[15:8], i[0] ? n[7:0] : s[7:0]}));
      ex(1, {3'h0, 3'h7});
      ex(5, current_limit_level);
    end
    n[7:0] = 8'h40;
    bsfc_host_model_inst.wr(n, s, 3'h7, 9'h0);
    w(4);
    ex(1, {3'h7, 3'h0});
    n[7:0] = 8'h44;
    bsfc_host_model_inst.wr(n, s, 3'h7, 9'h0);
    w(3);
    ex(2, 3'h1);
    w(20);
    ex(2, 3'h0);
    ex(0, tl(n));
    bsfc_host_model_inst.wr(n, s, 3'h6, 9'h0);
    w(4);
    ex(1, {3'h6, 3'h1});
    bsfc_host_model_inst.wr(n, s, 3'h7, 9'h0);
    tk(15, 3'h1, 3'h0, 3'h0);
    tk(1, 3'h0, 3'h0, 3'h0);
    tk(15, 3'h1, 3'h0, 3'h0);
    w(2);
    ex(3, 4'h1);
    tk(1, 3'h1, 3'h0, 3'h0);
    w(2);
    ex(3, 4'h2);
    bsfc_host_model_inst.rd();
    w(2);
    ex(3, 4'h2);
    tk(1, 3'h0, 3'h0, 3'h0);
    bsfc_host_model_inst.rd();
    w(2);
    ex(3, 4'h1);
    bsfc_host_model_inst.wr(n, s, 3'h7, 9'h002);
    tk(16, 3'h2, 3'h2, 3'h0);
    w(2);
    ex(3, 4'h5);
    ex(5, {3'h2, 3'h0, current_limit_level});
    tk(1, 3'h0, 3'h0, 3'h0);
    bsfc_host_model_inst.rd();
    bsfc_host_model_inst.wr(n, s, 3'h7, 9'h100);
    tk(1, 3'h0, 3'h0, 3'h4);
    tk(1, 3'h0, 3'h0, 3'h0);
    ex(4, {3'h4, 3'h3});
    w(30);
    ex(4, {3'h4, 3'h7});
    bsfc_host_model_inst.wr(n, s, 3'h7, 9'h0);
    tk(1, 3'h0, 3'h0, 3'h2);
    tk(1, 3'h0, 3'h0, 3'h0);
    ex(4, {3'h6, 3'h0});
    w(40);
    ex(6, 45'h1);
    w(2);
    results();
  end
endmodule
